// ### hw/fbc_pkg.sv
// Package of constants and types for the flash bus controller (host side).
package fbc_pkg;

  // Bus geometry.
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // Clock rate and derived timing.
  localparam int CLK_PERIOD_PS = 5000;
  // Address access time in ns, plus the sleep margin in ns.
  localparam int ADDR_ACCESS_NS = 90;
  localparam int SLEEP_MARGIN_NS = 30;
  // Minimum low time of the hardware clear pulse, in ns.
  localparam int CLEAR_PULSE_MIN_NS = 500;
  // Delay from clear release until reads are valid, in ns.
  localparam int CLEAR_TO_READ_NS = 50;
  // Strobe low time for a write cycle, in ns.
  localparam int WRITE_PULSE_NS = 35;
  // Least times round up to whole cycles.
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLEAR_CYC = (CLEAR_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_CYC = (CLEAR_TO_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WPULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  // Address bits used by the high-voltage protect and verify procedures.
  localparam int ADDR_BIT_A1 = 1;
  localparam int ADDR_BIT_A6 = 6;
  localparam int ADDR_BIT_A9 = 9;

  // Verify code on the low data byte for a protected group.
  localparam logic [7:0] PROT_CODE = 8'h01;
  localparam logic [7:0] UNPROT_CODE = 8'h00;

  // Host commands.
  typedef enum logic [2:0] {
    FBC_CMD_READ,
    FBC_CMD_WRITE,
    FBC_CMD_CLEAR,
    FBC_CMD_PROTECT,
    FBC_CMD_UNPROTECT,
    FBC_CMD_VERIFY
  } fbc_cmd_t;

endpackage

// ### hw/fbc_wait.sv
// Down counter that times one bus phase.
`timescale 1ns/1ps
`default_nettype none
module fbc_wait
  import fbc_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Load and status.
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] cnt_r;

  // Counts down to zero; done is high once the count expires.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Done looks at the count alone; gating it with load would close a loop through the caller.
  assign done_o = (cnt_r == '0);

endmodule
`default_nettype wire

// ### hw/fbc_host.sv
// Host-side controller that drives the flash pins for read, write, clear and protection.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Read drives select and gate low, strobe high.
// - Write drives strobe and select low, gate high.
// - Protect: high level on A9, gate; A6 low.
// - Temporary unprotect uses high level on clear.
// - Unprotect: high level on gate, A9; A6 high.
module fbc_host
  import fbc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Command port.
  input  wire logic          req_valid_i,
  input  wire fbc_cmd_t      req_cmd_i,
  input  wire logic [AW-1:0] req_addr_i,
  input  wire logic [DW-1:0] req_wdata_i,
  input  wire logic          temp_unprot_i,
  input  wire logic          boot_lock_i,
  input  wire logic          accel_i,
  output logic               req_ready_o,
  output logic               rsp_valid_o,
  output logic [DW-1:0]      rsp_rdata_o,
  output logic               rsp_prot_o,
  // Flash pins.
  output logic               chip_enable_n_o,
  output logic               output_gate_n_o,
  output logic               write_strobe_n_o,
  output logic               hardware_clear_n_o,
  output logic               clear_hv_o,
  output logic               gate_hv_o,
  output logic               a9_hv_o,
  output logic               boot_lock_accel_pin_o,
  output logic               accel_hv_o,
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      data_o,
  output logic               data_oe_o,
  input  wire logic [DW-1:0] data_i,
  input  wire logic          busy_indicator_i
);

  typedef enum logic [2:0] {
    FBC_IDLE,
    FBC_RD_WAIT,
    FBC_WR_PULSE,
    FBC_WR_HOLD,
    FBC_CLR_LOW,
    FBC_CLR_BUSY,
    FBC_CLR_REC
  } fbc_state_t;

  fbc_state_t         state_r;
  fbc_cmd_t           cmd_r;
  logic               wait_load;
  logic [CNT_W-1:0]   wait_cnt;
  logic               wait_done;
  logic               accepted;

  assign accepted = req_valid_i && req_ready_o;

  fbc_wait #(.W(CNT_W)) u_wait (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (wait_load),
    .count_i (wait_cnt),
    .done_o  (wait_done)
  );

  // Phase timer loads on entry to each timed phase.
  always_comb begin
    wait_load = 1'b0;
    wait_cnt = '0;
    if (accepted) begin
      wait_load = 1'b1;
      unique case (req_cmd_i)
        FBC_CMD_CLEAR: wait_cnt = CNT_W'(CLEAR_CYC);
        FBC_CMD_READ, FBC_CMD_VERIFY: wait_cnt = CNT_W'(ACCESS_CYC);
        default: wait_cnt = CNT_W'(WPULSE_CYC);
      endcase
    end else if (state_r == FBC_WR_PULSE && wait_done) begin
      wait_load = 1'b1;
      wait_cnt = CNT_W'(WPULSE_CYC);
    end else if (state_r == FBC_CLR_BUSY && busy_indicator_i) begin
      wait_load = 1'b1;
      wait_cnt = CNT_W'(RECOVER_CYC);
    end
  end

  // Main sequencer.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= FBC_IDLE;
      cmd_r <= FBC_CMD_READ;
    end else begin
      unique case (state_r)
        FBC_IDLE: begin
          if (accepted) begin
            cmd_r <= req_cmd_i;
            unique case (req_cmd_i)
              FBC_CMD_READ, FBC_CMD_VERIFY: state_r <= FBC_RD_WAIT;
              FBC_CMD_CLEAR: state_r <= FBC_CLR_LOW;
              default: state_r <= FBC_WR_PULSE;
            endcase
          end
        end
        FBC_RD_WAIT: if (wait_done) state_r <= FBC_IDLE;
        FBC_WR_PULSE: if (wait_done) state_r <= FBC_WR_HOLD;
        FBC_WR_HOLD: if (wait_done) state_r <= FBC_IDLE;
        FBC_CLR_LOW: if (wait_done) state_r <= FBC_CLR_BUSY;
        FBC_CLR_BUSY: if (busy_indicator_i) state_r <= FBC_CLR_REC;
        FBC_CLR_REC: if (wait_done) state_r <= FBC_IDLE;
      endcase
    end
  end

  // Ready only in idle; a clear aborts nothing on the host side mid-cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state_r == FBC_IDLE) && !accepted && !req_ready_o ? 1'b1
                   : (state_r == FBC_IDLE && !accepted);
    end
  end

  // Pin strobes, registered from the next state.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      chip_enable_n_o <= 1'b1;
      output_gate_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      hardware_clear_n_o <= 1'b1;
      gate_hv_o <= 1'b0;
      a9_hv_o <= 1'b0;
      data_oe_o <= 1'b0;
    end else if (accepted) begin
      chip_enable_n_o <= (req_cmd_i == FBC_CMD_CLEAR);
      hardware_clear_n_o <= (req_cmd_i != FBC_CMD_CLEAR);
      output_gate_n_o <= !(req_cmd_i == FBC_CMD_READ || req_cmd_i == FBC_CMD_VERIFY);
      write_strobe_n_o <= !(req_cmd_i == FBC_CMD_WRITE || req_cmd_i == FBC_CMD_PROTECT
                            || req_cmd_i == FBC_CMD_UNPROTECT);
      data_oe_o <= (req_cmd_i == FBC_CMD_WRITE);
      // high level on gate and A9.
      gate_hv_o <= (req_cmd_i == FBC_CMD_PROTECT || req_cmd_i == FBC_CMD_UNPROTECT);
      a9_hv_o <= (req_cmd_i == FBC_CMD_PROTECT || req_cmd_i == FBC_CMD_UNPROTECT
                  || req_cmd_i == FBC_CMD_VERIFY);
    end else if (state_r == FBC_WR_PULSE && wait_done) begin
      write_strobe_n_o <= 1'b1;
    end else if (state_r == FBC_CLR_LOW && wait_done) begin
      hardware_clear_n_o <= 1'b1;
    end else if ((state_r == FBC_RD_WAIT || state_r == FBC_WR_HOLD) && wait_done) begin
      chip_enable_n_o <= 1'b1;
      output_gate_n_o <= 1'b1;
      data_oe_o <= 1'b0;
      gate_hv_o <= 1'b0;
      a9_hv_o <= 1'b0;
    end
  end

  // Address and data hold from the accepted request.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_o <= '0;
      data_o <= '0;
    end else if (accepted) begin
      addr_o <= req_addr_i;
      data_o <= req_wdata_i;
      if (req_cmd_i == FBC_CMD_PROTECT) addr_o[ADDR_BIT_A6] <= 1'b0;
      if (req_cmd_i == FBC_CMD_UNPROTECT) addr_o[ADDR_BIT_A6] <= 1'b1;
      if (req_cmd_i == FBC_CMD_VERIFY) addr_o[ADDR_BIT_A1] <= 1'b1;
    end
  end

  // Static level pins follow the host controls.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clear_hv_o <= 1'b0;
      boot_lock_accel_pin_o <= 1'b0;
      accel_hv_o <= 1'b0;
    end else begin
      clear_hv_o <= temp_unprot_i;
      boot_lock_accel_pin_o <= boot_lock_i;
      // accel held while idle and through plain writes only.
      // The level drops on the edge that starts any other cycle, so no read or
      // protection step ever sees it on the pin.
      accel_hv_o <= accel_i && (accepted ? (req_cmd_i == FBC_CMD_WRITE)
                                         : (state_r == FBC_IDLE
                                            || ((state_r == FBC_WR_PULSE
                                                 || state_r == FBC_WR_HOLD)
                                                && cmd_r == FBC_CMD_WRITE)));
    end
  end

  // Read data captured at the end of the access time.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      rsp_prot_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_r == FBC_RD_WAIT) && wait_done;
      if (state_r == FBC_RD_WAIT && wait_done) begin
        rsp_rdata_o <= data_i;
        rsp_prot_o <= (cmd_r == FBC_CMD_VERIFY) && (data_i[7:0] == PROT_CODE);
      end
    end
  end

  a_read_levels: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == FBC_RD_WAIT && !wait_load) |-> (!output_gate_n_o && write_strobe_n_o))
    else $error("read cycle pin levels wrong");
  a_write_levels: assert property (@(posedge clk_i) disable iff (reset_i)
    !write_strobe_n_o |-> (!chip_enable_n_o && output_gate_n_o))
    else $error("write cycle pin levels wrong");
  a_clear_width: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(hardware_clear_n_o) |-> !hardware_clear_n_o [*8])
    else $error("clear pulse too short");
  a_clear_busy: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == FBC_CLR_BUSY && !busy_indicator_i) |=> (!req_ready_o && chip_enable_n_o))
    else $error("accepted work while device busy");
  a_accel_write_only: assert property (@(posedge clk_i) disable iff (reset_i)
    accel_hv_o |-> (hardware_clear_n_o && output_gate_n_o && !gate_hv_o))
    else $error("accel level outside a plain write");

endmodule
`default_nettype wire

// ### bench/fbc_flash_model.sv
// Behavioural model of the parallel flash device as seen at its pins.
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model
  import fbc_pkg::*;
#(
  // Kept off the clock grid so busy never rises in the step of a sampling edge.
  parameter int BUSY_NS = 701
) (
  // Control pins.
  input  wire logic              chip_enable_n_i,
  input  wire logic              output_gate_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic              hardware_clear_n_i,
  input  wire logic              clear_hv_i,
  input  wire logic              gate_hv_i,
  input  wire logic              a9_hv_i,
  input  wire logic              boot_lock_i,
  input  wire logic              accel_hv_i,
  // Address, data and busy.
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   busy_indicator_o
);
  logic [DATA_W-1:0] mem [int];
  logic [31:0]       prot_r;
  logic [DATA_W-1:0] last_r;
  logic              drive;
  logic              blocked;
  logic [4:0]        grp;
  initial begin
    prot_r = '0;
    last_r = '0;
    busy_indicator_o = 1'b1;
  end
  // Upper address bits pick the group.
  assign grp = addr_i[ADDR_W-1:17];
  assign blocked = (prot_r[grp] && !clear_hv_i && !accel_hv_i)
                 || (addr_i < 22'h002000 && !boot_lock_i && !accel_hv_i);
  // Outputs only on a selected read.
  assign drive = !chip_enable_n_i && !output_gate_n_i && hardware_clear_n_i;
  // Commit on strobe rise; clear low ignores it unless clear is at high level.
  always @(posedge write_strobe_n_i) begin
    if (!chip_enable_n_i && (hardware_clear_n_i || clear_hv_i)) begin
      if (gate_hv_i && a9_hv_i) begin
        if (!addr_i[ADDR_BIT_A6]) prot_r[grp] = 1'b1;
        else prot_r = '0;
      end else if (output_gate_n_i && !blocked) mem[int'(addr_i)] = data_i;
    end
  end
  // Read data.
  // Array read, or the group code when A9 is at high level with A1 set; a released bus shows the inverse.
  always @(drive, addr_i, a9_hv_i, prot_r, write_strobe_n_i) begin
    if (drive) begin
      if (a9_hv_i && addr_i[ADDR_BIT_A1]) data_o = {15'h0000, prot_r[grp]};
      else data_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'hFFFF;
      last_r = data_o;
    end else data_o = ~last_r;
  end
  // Busy low while internal reset runs, slower than the pulse.
  always @(negedge hardware_clear_n_i) begin
    busy_indicator_o = 1'b0;
    #(BUSY_NS) busy_indicator_o = 1'b1;
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the host-side flash bus controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fbc_pkg::*;
  logic clk_i, reset_i, req_valid_i, temp_unprot_i, boot_lock_i, accel_i;
  fbc_cmd_t req_cmd_i;
  logic [ADDR_W-1:0] req_addr_i, addr_o, a;
  logic [DATA_W-1:0] req_wdata_i, data_o, data_i, rdata, d;
  logic ce_n, oe_n, we_n, clr_n, clr_hv, gate_hv, a9_hv, bl, acc, busy, ready, rv, oe, prot;
  logic [DATA_W-1:0] exp_q[$];
  logic exp_p[$];
  int n_errors = 0;
  int n_compared = 0;
  fbc_host i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .temp_unprot_i(temp_unprot_i), .boot_lock_i(boot_lock_i), .accel_i(accel_i),
    .req_ready_o(ready), .rsp_valid_o(rv), .rsp_rdata_o(rdata), .rsp_prot_o(prot),
    .chip_enable_n_o(ce_n), .output_gate_n_o(oe_n), .write_strobe_n_o(we_n),
    .hardware_clear_n_o(clr_n), .clear_hv_o(clr_hv), .gate_hv_o(gate_hv), .a9_hv_o(a9_hv),
    .boot_lock_accel_pin_o(bl), .accel_hv_o(acc), .addr_o(addr_o), .data_o(data_o),
    .data_oe_o(oe), .data_i(data_i), .busy_indicator_i(busy));
  fbc_flash_model i_mem (.chip_enable_n_i(ce_n), .output_gate_n_i(oe_n),
    .write_strobe_n_i(we_n), .hardware_clear_n_i(clr_n), .clear_hv_i(clr_hv),
    .gate_hv_i(gate_hv), .a9_hv_i(a9_hv), .boot_lock_i(bl), .accel_hv_i(acc),
    .addr_i(addr_o), .data_i(data_o), .data_o(data_i), .busy_indicator_o(busy));
  // Free-running 200 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic cmp16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request held from a falling edge through the rising edge that takes it.
  task automatic req(input fbc_cmd_t c, input logic [ADDR_W-1:0] ad,
                     input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(negedge clk_i);
    while (ready !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk_i);
    end
    req_cmd_i = c;
    req_addr_i = ad;
    req_wdata_i = wd;
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic rd(input fbc_cmd_t c, input logic [ADDR_W-1:0] ad,
                    input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    // A verify read with Q0 set names a protected group.
    exp_p.push_back(c == FBC_CMD_VERIFY && e[0]);
    req(c, ad, '0);
  endtask
  // Responses are a one-cycle pulse, so look in mid-cycle.
  always @(negedge clk_i) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) cmp16(rdata, ~rdata);
      else begin
        cmp16(rdata, exp_q.pop_front());
        cmp1(prot, exp_p.pop_front());
      end
    end
  end
  // Cut a hang short.
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    int n;
    void'($urandom(42249));
    {reset_i, req_valid_i, temp_unprot_i, boot_lock_i, accel_i} = 5'b10010;
    req_cmd_i = FBC_CMD_READ;
    req_addr_i = '0;
    req_wdata_i = '0;
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    rd(FBC_CMD_READ, 22'h123456, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      a = ADDR_W'($urandom) | 22'h100000;
      d = DATA_W'($urandom);
      req(FBC_CMD_WRITE, a, d);
      rd(FBC_CMD_READ, a, d);
    end
    req(FBC_CMD_WRITE, 22'h060040, 16'h1234);
    req(FBC_CMD_PROTECT, 22'h060040, '0);
    rd(FBC_CMD_VERIFY, 22'h060040, {8'h00, PROT_CODE});
    rd(FBC_CMD_VERIFY, 22'h0E0000, {8'h00, UNPROT_CODE});
    req(FBC_CMD_WRITE, 22'h078000, 16'h5555);
    rd(FBC_CMD_READ, 22'h078000, 16'hFFFF);
    temp_unprot_i = 1'b1;
    req(FBC_CMD_WRITE, 22'h078000, 16'h5555);
    rd(FBC_CMD_READ, 22'h078000, 16'h5555);
    {temp_unprot_i, boot_lock_i} = 2'b00;
    req(FBC_CMD_WRITE, 22'h001000, 16'hAAAA);
    rd(FBC_CMD_READ, 22'h001000, 16'hFFFF);
    boot_lock_i = 1'b1;
    req(FBC_CMD_WRITE, 22'h001000, 16'hAAAA);
    rd(FBC_CMD_READ, 22'h001000, 16'hAAAA);
    req(FBC_CMD_UNPROTECT, 22'h060040, '0);
    rd(FBC_CMD_VERIFY, 22'h060040, {8'h00, UNPROT_CODE});
    req(FBC_CMD_CLEAR, '0, '0);
    rd(FBC_CMD_READ, 22'h060040, 16'h1234);
    req(FBC_CMD_PROTECT, 22'h060040, '0);
    accel_i = 1'b1;
    req(FBC_CMD_WRITE, 22'h060040, 16'h7777);
    rd(FBC_CMD_READ, 22'h060040, 16'h7777);
    accel_i = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      n++;
      @(negedge clk_i);
    end
    if (exp_q.size() != 0) n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
